// *** rtl/asf_pkg.sv ***
package asf_pkg;
	localparam logic [2:0] ADDR_SEL = 3'h0;
	localparam logic [2:0] ADDR_CTRL = 3'h1;
	localparam logic [2:0] ADDR_CSB = 3'h2;
	localparam logic [2:0] ADDR_RESL = 3'h3;
	localparam logic [2:0] ADDR_RESH = 3'h4;
	localparam int SEL_LEFT = 5;
	localparam int CTRL_EN = 0;
	localparam int CTRL_START = 1;
	localparam int CTRL_IE = 2;
	localparam int CTRL_FLAG = 3;
	localparam int CSB_BIP = 7;
	localparam int CSB_IPR = 5;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [4:0] NORMAL_CYC = 5'h0d;
	localparam logic [4:0] FIRST_CYC = 5'h19;
	localparam logic [7:0] PRESC_DEFAULT = 8'h02;
	localparam logic [1:0] SLP_IDLE = 2'h0;
	localparam logic [1:0] SLP_NOISE = 2'h1;
	localparam logic [9:0] UNI_MAX = 10'h3ff;
	localparam logic [9:0] BIP_MAX = 10'h1ff;
	localparam logic [9:0] BIP_MIN = 10'h200;
	localparam logic [3:0] MUX_BANDGAP = 4'hc;
	localparam logic [3:0] MUX_ZERO = 4'hd;
	localparam logic [3:0] MUX_TEMP = 4'hf;
	localparam logic [2:0] TEMP_INPUT = 3'h4;
	typedef enum logic [2:0] {
		REF_VCC = 3'h0,
		REF_EXT = 3'h1,
		REF_1V1 = 3'h2,
		REF_1V1_BYP = 3'h3,
		REF_2V56 = 3'h6,
		REF_2V56_BYP = 3'h7
	} asf_ref_type;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} asf_state_type;
endpackage : asf_pkg

// *** rtl/asf_top.sv ***
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
module asf_top #(
	parameter logic [7:0] PRESC = asf_pkg::PRESC_DEFAULT
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata,
	input wire logic sleep_cmd,
	input wire logic [1:0] sleep_mode,
	input wire logic cpu_halted,
	input wire logic irq_ack,
	output logic irq_req,
	output logic cpu_wake,
	input wire logic signed [11:0] samp_diff,
	output logic busy,
	output logic [2:0] pos_input,
	output logic [2:0] neg_input,
	output logic diff_mode,
	output logic gain_20x,
	output logic temp_sensor_en,
	output logic bandgap_sel,
	output logic zero_sel,
	output logic [2:0] reference_select,
	output logic int_ref_on,
	output logic ext_ref_pin_conn
);
	typedef struct packed {
		asf_pkg::asf_state_type st;
		logic [7:0] sel;
		logic en;
		logic ie;
		logic flag;
		logic bip;
		logic polarity_reversal;
		logic lng;
		logic [7:0] pre;
		logic [4:0] cnt;
		logic [9:0] res;
		logic [3:0] amux;
		logic [2:0] external_reference_pin;
		logic armed;
		logic slp;
		logic wake;
		logic irq;
		logic [7:0] rd;
		logic [2:0] pos;
		logic [2:0] neg;
		logic diff;
		logic g20;
		logic temp;
		logic bg;
		logic zero;
	} asf_state_s_type;

	asf_state_s_type s_q;
	asf_state_s_type s_d;
	logic tick;
	logic done;
	logic start;
	logic [9:0] fmt;

	function automatic logic [9:0] asf_format(input logic signed [11:0] d, input logic df, input logic bp);
		logic signed [11:0] h;
		h = d >>> 1;
		if (df && bp) begin
			if (h > 12'sd511) begin
				asf_format = asf_pkg::BIP_MAX;
			end else if (h < -12'sd512) begin
				asf_format = asf_pkg::BIP_MIN;
			end else begin
				asf_format = h[9:0];
			end
		end else if (d < 12'sd0) begin
			asf_format = 10'h000;
		end else if (d > 12'sd1023) begin
			asf_format = asf_pkg::UNI_MAX;
		end else begin
			asf_format = d[9:0];
		end
	endfunction : asf_format

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.wake = 1'b0;
		tick = s_q.pre == PRESC - 8'h01;
		done = s_q.st == asf_pkg::ST_CONV && tick && s_q.cnt == 5'h01;
		fmt = asf_format(samp_diff, s_q.diff, s_q.bip);
		start = 1'b0;
		// register writes
		if (we) begin
			unique case (addr)
				asf_pkg::ADDR_SEL: s_d.sel = wdata;
				asf_pkg::ADDR_CTRL: begin
					s_d.en = wdata[asf_pkg::CTRL_EN];
					s_d.ie = wdata[asf_pkg::CTRL_IE];
					if (wdata[asf_pkg::CTRL_FLAG]) begin
						s_d.flag = 1'b0;
					end
					if (wdata[asf_pkg::CTRL_EN] && !s_q.en) begin
						s_d.lng = 1'b1;
					end
					start = wdata[asf_pkg::CTRL_START] && wdata[asf_pkg::CTRL_EN];
				end
				asf_pkg::ADDR_CSB: begin
					s_d.bip = wdata[asf_pkg::CSB_BIP];
					s_d.polarity_reversal = wdata[asf_pkg::CSB_IPR];
				end
				default: begin
				end
			endcase
		end
		if (irq_ack) begin
			s_d.flag = 1'b0;
		end
		// idle or noise-reduction sleep entry arms the canceler; other modes leave enable alone
		if (sleep_cmd) begin
			s_d.armed = (sleep_mode == asf_pkg::SLP_IDLE || sleep_mode == asf_pkg::SLP_NOISE)
				&& s_q.en && s_q.ie && s_q.st == asf_pkg::ST_IDLE;
		end
		if (s_q.armed && cpu_halted && s_q.st == asf_pkg::ST_IDLE && s_q.en) begin
			start = 1'b1;
			s_d.armed = 1'b0;
			s_d.slp = 1'b1;
		end
		// prescaler runs only while enabled
		s_d.pre = (!s_q.en || tick) ? 8'h00 : s_q.pre + 8'h01;
		if (s_q.st == asf_pkg::ST_IDLE) begin
			s_d.amux = s_q.sel[3:0];
			s_d.external_reference_pin = {s_q.sel[4], s_q.sel[7:6]};
			if (s_d.external_reference_pin != s_q.external_reference_pin) begin
				s_d.lng = 1'b1;
			end
			if (start) begin
				s_d.st = asf_pkg::ST_CONV;
				s_d.pre = 8'h00;
				s_d.cnt = s_d.lng ? asf_pkg::FIRST_CYC : asf_pkg::NORMAL_CYC;
				s_d.lng = 1'b0;
			end
		end else if (done) begin
			s_d.st = asf_pkg::ST_IDLE;
			s_d.res = fmt;
			s_d.flag = 1'b1;
			s_d.wake = s_q.slp && cpu_halted;
			s_d.slp = 1'b0;
		end else if (tick) begin
			s_d.cnt = s_q.cnt - 5'h01;
		end
		if (!s_q.en && s_q.st == asf_pkg::ST_CONV) begin
			s_d.st = asf_pkg::ST_IDLE;
			s_d.slp = 1'b0;
		end
		s_d.irq = s_d.flag && s_d.ie;
		// multiplexer decode of the locked selection
		s_d.pos = 3'h0;
		s_d.neg = 3'h0;
		s_d.diff = 1'b0;
		s_d.g20 = 1'b0;
		s_d.temp = 1'b0;
		s_d.bg = 1'b0;
		s_d.zero = 1'b0;
		if (s_d.amux < 4'h4) begin
			s_d.pos = s_d.amux[2:0];
		end else if (s_d.amux < 4'h8) begin
			s_d.diff = 1'b1;
			s_d.pos = 3'h2;
			s_d.neg = s_d.amux[1] ? 3'h3 : 3'h2;
		end else if (s_d.amux < asf_pkg::MUX_BANDGAP) begin
			s_d.diff = 1'b1;
			s_d.pos = 3'h0;
			s_d.neg = s_d.amux[1] ? 3'h1 : 3'h0;
		end else begin
			s_d.bg = s_d.amux == asf_pkg::MUX_BANDGAP;
			s_d.zero = s_d.amux == asf_pkg::MUX_ZERO;
			s_d.temp = s_d.amux == asf_pkg::MUX_TEMP;
			s_d.pos = s_d.temp ? asf_pkg::TEMP_INPUT : 3'h0;
		end
		if (s_d.diff) begin
			s_d.g20 = s_d.amux[0];
			if (s_d.polarity_reversal && !s_d.bip) begin
				s_d.pos = s_d.neg;
				s_d.neg = s_d.amux[1] ? (s_d.amux[3] ? 3'h0 : 3'h2) : s_d.pos;
			end
		end
		// read data, one cycle after the strobe
		s_d.rd = 8'h00;
		if (re) begin
			unique case (addr)
				asf_pkg::ADDR_SEL: s_d.rd = s_q.sel;
				asf_pkg::ADDR_CTRL: s_d.rd = {4'h0, s_q.flag, s_q.ie, s_q.st == asf_pkg::ST_CONV, s_q.en};
				asf_pkg::ADDR_CSB: s_d.rd = {s_q.bip, 1'b0, s_q.polarity_reversal, 5'h00};
				asf_pkg::ADDR_RESL: s_d.rd = s_q.sel[asf_pkg::SEL_LEFT] ? {s_q.res[1:0], 6'h00} : s_q.res[7:0];
				asf_pkg::ADDR_RESH: s_d.rd = s_q.sel[asf_pkg::SEL_LEFT] ? s_q.res[9:2] : {6'h00, s_q.res[9:8]};
				default: s_d.rd = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rd;
	assign irq_req = s_q.irq;
	assign cpu_wake = s_q.wake;
	assign busy = s_q.st == asf_pkg::ST_CONV;
	assign pos_input = s_q.pos;
	assign neg_input = s_q.neg;
	assign diff_mode = s_q.diff;
	assign gain_20x = s_q.g20;
	assign temp_sensor_en = s_q.temp;
	assign bandgap_sel = s_q.bg;
	assign zero_sel = s_q.zero;
	assign reference_select = s_q.external_reference_pin;
	assign int_ref_on = s_q.external_reference_pin[1];
	assign ext_ref_pin_conn = s_q.external_reference_pin[0];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sleep_start_a: assert property (s_q.armed && cpu_halted && s_q.en && s_q.st == asf_pkg::ST_IDLE
		|=> s_q.st == asf_pkg::ST_CONV && s_q.slp) else $error("sleep did not start conversion");
	wake_done_a: assert property (done && s_q.slp && cpu_halted |=> cpu_wake) else $error("no wake");
	irq_done_a: assert property (done && s_q.ie && !we && !irq_ack |=> irq_req) else $error("no irq");
	stay_awake_a: assert property (cpu_wake && !sleep_cmd |-> !s_q.armed ##1 !s_q.armed)
		else $error("rearmed without sleep");
	enable_kept_a: assert property (sleep_cmd && !we |=> s_q.en == $past(s_q.en))
		else $error("sleep changed enable");
	result_flag_a: assert property (done |=> s_q.flag && s_q.res == $past(fmt))
		else $error("result not stored");
	uni_clamp_a: assert property (done && !(s_q.diff && s_q.bip) && samp_diff < 0 |=> s_q.res == 10'h000)
		else $error("no saturation");
	bip_sign_a: assert property (done && s_q.diff && s_q.bip |=> s_q.res[9] == $past(samp_diff[11]))
		else $error("bad sign");
	sel_lock_a: assert property (s_q.st == asf_pkg::ST_CONV ##1 s_q.st == asf_pkg::ST_CONV
		|-> $stable(s_q.amux) && $stable(s_q.external_reference_pin)) else $error("selection moved");
	long_conv_a: assert property (s_q.st == asf_pkg::ST_IDLE && $past(s_q.external_reference_pin) != s_q.external_reference_pin ##1
		$rose(busy) |-> s_q.cnt == asf_pkg::FIRST_CYC) else $error("short conversion");
	left_read_a: assert property (re && addr == asf_pkg::ADDR_RESH && !done
		|=> rdata == ($past(s_q.sel[5]) ? $past(s_q.res[9:2]) : {6'h00, $past(s_q.res[9:8])}))
		else $error("bad high byte");
	offset_a: assert property (s_q.amux[3:1] == 3'h4 |-> pos_input == neg_input)
		else $error("offset not same input");
	low_read_a: assert property (re && addr == asf_pkg::ADDR_RESL
		|=> rdata == ($past(s_q.sel[5]) ? {$past(s_q.res[1:0]), 6'h00} : $past(s_q.res[7:0])))
		else $error("bad low byte");
	idle_read_a: assert property (!re |=> rdata == 8'h00) else $error("read data without strobe");
	bip_clip_a: assert property (done && s_q.diff && s_q.bip && samp_diff > 12'sd1023
		|=> s_q.res == asf_pkg::BIP_MAX) else $error("bipolar not clipped");
	uni_top_a: assert property (done && !(s_q.diff && s_q.bip) && samp_diff > 12'sd1023
		|=> s_q.res == asf_pkg::UNI_MAX) else $error("unipolar not clipped");
	temp_input_a: assert property (temp_sensor_en |-> pos_input == asf_pkg::TEMP_INPUT)
		else $error("temperature input wrong");
	other_sleep_a: assert property (sleep_cmd && sleep_mode > asf_pkg::SLP_NOISE |=> !s_q.armed)
		else $error("armed in deep sleep");

	sleep_conv_c: cover property (s_q.slp ##1 cpu_wake);
	bip_c: cover property (done && s_q.bip && s_q.diff);
	long_c: cover property ($rose(busy) && s_q.cnt == asf_pkg::FIRST_CYC);
endmodule : asf_top

// *** sim/asf_cpu_model.sv ***
`timescale 1ns/10ps
module asf_cpu_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic go,
	input wire logic [1:0] mode_in,
	input wire logic wake_early,
	input wire logic cpu_wake,
	input wire logic signed [11:0] level,
	output logic sleep_cmd,
	output logic [1:0] sleep_mode,
	output logic cpu_halted,
	output logic signed [11:0] samp_diff
);
	assign samp_diff = level;
	always_ff @(posedge clock) begin
		if (srst) begin
			sleep_cmd <= 1'b0;
			sleep_mode <= 2'h0;
			cpu_halted <= 1'b0;
		end else begin
			sleep_cmd <= go;
			if (go) begin
				sleep_mode <= mode_in;
			end
			if (sleep_cmd) begin
				cpu_halted <= 1'b1;
			end else if (cpu_wake || wake_early) begin
				cpu_halted <= 1'b0;
			end
		end
	end
endmodule : asf_cpu_model

// *** sim/adc_select_and_result_format_tb.sv ***
`timescale 1ns/10ps
module adc_select_and_result_format_tb;
	logic clock, srst, we, re, irq_ack, go, wake_early, sleep_cmd, cpu_halted, irq_req, cpu_wake, busy;
	logic diff_mode, gain_20x, temp_sensor_en, bandgap_sel, zero_sel, int_ref_on, ext_ref_pin_conn;
	logic [2:0] addr, pos_input, neg_input, reference_select;
	logic [7:0] wdata, rdata, rv;
	logic [1:0] mode_in, sleep_mode;
	logic signed [11:0] level, samp_diff;
	int fail_count, num_checks, n1, n2, n3, c;
	asf_top #(.PRESC(8'h02)) uut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata(rdata), .sleep_cmd(sleep_cmd), .sleep_mode(sleep_mode), .cpu_halted(cpu_halted),
		.irq_ack(irq_ack), .irq_req(irq_req), .cpu_wake(cpu_wake), .samp_diff(samp_diff), .busy(busy),
		.pos_input(pos_input), .neg_input(neg_input), .diff_mode(diff_mode), .gain_20x(gain_20x),
		.temp_sensor_en(temp_sensor_en), .bandgap_sel(bandgap_sel), .zero_sel(zero_sel),
		.reference_select(reference_select), .int_ref_on(int_ref_on), .ext_ref_pin_conn(ext_ref_pin_conn));
	asf_cpu_model cpu (.clock(clock), .srst(srst), .go(go), .mode_in(mode_in), .wake_early(wake_early),
		.cpu_wake(cpu_wake), .level(level), .sleep_cmd(sleep_cmd), .sleep_mode(sleep_mode),
		.cpu_halted(cpu_halted), .samp_diff(samp_diff));
	////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clock);
		we <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] a);
		@(posedge clock);
		addr <= a;
		re <= 1'b1;
		@(posedge clock);
		re <= 1'b0;
		#1;
		rv = rdata;
	endtask : rd
	task wait_done(output int n);
		int i;
		n = 0;
		for (i = 0; i < 400; i++) begin
			tick(1);
			if (busy) n++;
			else if (n > 0) break;
		end
		if (i == 400) begin
			fail_count++;
			summarize();
		end
	endtask : wait_done
	task conv(output int n);
		wr(3'h1, 8'h07);
		wait_done(n);
	endtask : conv
	task res(input logic [9:0] r, input bit left);
		rd(3'h3);
		chk("result_low", rv, left ? {r[1:0], 6'h00} : r[7:0]);
		rd(3'h4);
		chk("result_high", rv, left ? r[9:2] : {6'h00, r[9:8]});
	endtask : res
	task sleep_go(input logic [1:0] m);
		@(posedge clock);
		mode_in <= m;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
	endtask : sleep_go
	task pulse_wake;
		@(posedge clock);
		wake_early <= 1'b1;
		@(posedge clock);
		wake_early <= 1'b0;
	endtask : pulse_wake
	task ack;
		@(posedge clock);
		irq_ack <= 1'b1;
		@(posedge clock);
		irq_ack <= 1'b0;
		tick(2);
	endtask : ack
	////////////////////////////////////////////////////////////
	task t_select;
		rd(3'h0);
		chk("sel_reset", rv, 8'h00);
		wr(3'h0, 8'ha5);
		rd(3'h0);
		chk("sel_rw", rv, 8'ha5);
		rd(3'h7);
		chk("unmapped", rv, 8'h00);
		for (c = 0; c < 16; c++) begin
			wr(3'h0, 8'(c));
			tick(2);
			chk("bandgap", bandgap_sel, c == 12);
			chk("zero", zero_sel, c == 13);
			chk("temp", temp_sensor_en, c == 15);
			chk("diff", diff_mode, c > 3 && c < 12);
			if (c < 4 || c == 15) chk("pos", pos_input, c == 15 ? 4 : c);
			if (c > 3 && c < 12) chk("gain", gain_20x, c % 2);
			if (c == 8 || c == 9) chk("offset", {pos_input, neg_input}, 6'h00);
			if (c > 3 && c < 12) chk("pair", {pos_input, neg_input}, c < 6 ? 6'h12 : c < 8 ? 6'h13 : c < 10 ? 6'h00 : 6'h01);
		end
		wr(3'h2, 8'h20);
		wr(3'h0, 8'h0a);
		tick(2);
		chk("reversed", {pos_input, neg_input}, 6'h08);
		wr(3'h2, 8'h00);
		for (c = 0; c < 8; c++) begin
			if (c == 4 || c == 5) continue;
			wr(3'h0, {c[1:0], 1'b0, c[2], 4'h0});
			tick(2);
			chk("ref", {int_ref_on, ext_ref_pin_conn, reference_select}, {c[1:0], c[2:0]});
		end
		wr(3'h0, 8'h00);
		$display("test select done");
	endtask : t_select
	task t_convert;
		level <= 12'h2a5;
		conv(n1);
		res(10'h2a5, 0);
		wr(3'h0, 8'h20);
		res(10'h2a5, 1);
		wr(3'h0, 8'h00);
		conv(n2);
		wr(3'h1, 8'h07);
		wr(3'h0, 8'h83);
		tick(1);
		chk("locked", {pos_input, reference_select}, 6'h00);
		wait_done(n3);
		tick(2);
		chk("updated", {pos_input, reference_select}, 6'h1a);
		conv(n3);
		chk("first_len", n1 - n2, 24);
		chk("ref_len", n3 - n2, 24);
		wr(3'h0, 8'h0a);
		level <= -12'sd5;
		conv(n1);
		res(10'h000, 0);
		level <= 12'h155;
		conv(n1);
		res(10'h155, 0);
		wr(3'h2, 8'h80);
		rd(3'h2);
		chk("bipolar_bit", rv, 8'h80);
		level <= -12'sd100;
		conv(n1);
		res(10'h3ce, 0);
		chk("sign_neg", rv[1], 1'b1);
		level <= 12'h7ff;
		conv(n1);
		res(10'h1ff, 0);
		chk("sign_pos", rv[1], 1'b0);
		wr(3'h2, 8'h00);
		$display("test convert done");
	endtask : t_convert
	task t_sleep;
		wr(3'h1, 8'h0d);
		tick(2);
		sleep_go(2'h1);
		for (c = 0; c < 400 && cpu_wake !== 1'b1; c++) tick(1);
		chk("wake", cpu_wake, 1'b1);
		tick(2);
		chk("irq", irq_req, 1'b1);
		ack();
		sleep_go(2'h0);
		tick(6);
		chk("sleep_busy", busy, 1'b1);
		pulse_wake();
		wait_done(n1);
		tick(2);
		chk("late_irq", {irq_req, cpu_halted}, 2'b10);
		chk("no_rearm", busy, 1'b0);
		ack();
		sleep_go(2'h2);
		tick(10);
		chk("deep_idle", busy, 1'b0);
		rd(3'h1);
		chk("still_enabled", rv[0], 1'b1);
		pulse_wake();
		$display("test sleep done");
	endtask : t_sleep
	////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		{srst, we, re, irq_ack, go, wake_early} = 6'b100000;
		{addr, wdata, mode_in, level} = 25'h0;
		fail_count = 0;
		num_checks = 0;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		t_select();
		t_convert();
		t_sleep();
		summarize();
	end
endmodule : adc_select_and_result_format_tb
